/* File: pkg/radio_irq_consts.svh */
`ifndef RADIO_IRQ_CONSTS_SVH
`define RADIO_IRQ_CONSTS_SVH

// ----------------------------------------
// Register selects on the register port
// ----------------------------------------
`define SEL_BB_STATUS 4'h0
`define SEL_LOW_STATUS 4'h1
`define SEL_HIGH_STATUS 4'h2
`define SEL_BB_MASK 4'h3
`define SEL_LOW_MASK 4'h4
`define SEL_HIGH_MASK 4'h5
`define SEL_CFG 4'h6
`define SEL_THR_LO 4'h7
`define SEL_THR_HI 4'h8

// ----------------------------------------
// Baseband status bit positions
// ----------------------------------------
`define BB_BUFFER_LEVEL 7
`define BB_GAIN_RELEASE 6
`define BB_GAIN_HOLD 5
`define BB_TX_DONE 4
`define BB_EXT_MATCH 3
`define BB_ADDR_MATCH 2
`define BB_RX_DONE 1
`define BB_RX_START 0

// ----------------------------------------
// Radio status bit positions
// ----------------------------------------
`define RF_WAKEUP 0
`define RF_TRX_READY 1
`define RF_EVT_LSB 2

// ----------------------------------------
// Configuration fields and reset values
// ----------------------------------------
`define CFG_MASK_MODE 3
`define CFG_RESET 8'h08
`define MASK_RESET 8'h00
`define STATUS_RESET 8'h00
`define THR_RESET 11'h000

`endif

/* File: pkg/radio_irq_pkg.sv */
package radio_irq_pkg;

  typedef enum logic [2:0] {
    ST_POWER_ON = 3'b000,
    ST_TRXOFF = 3'b001,
    ST_TRANSMIT_PREPARE_STATE = 3'b010,
    ST_TX = 3'b011,
    ST_RX = 3'b100,
    ST_SLEEP = 3'b101,
    ST_DEEP_SLEEP = 3'b110,
    ST_RESET = 3'b111
  } trx_state_e;

  typedef enum logic [2:0] {
    CMD_NOP = 3'b000,
    CMD_SLEEP = 3'b001,
    CMD_TRXOFF = 3'b010,
    CMD_TRANSMIT_PREPARE_STATE = 3'b011,
    CMD_TX = 3'b100,
    CMD_RX = 3'b101,
    CMD_RESET = 3'b110
  } trx_cmd_e;

  typedef logic [7:0] byte_t;

endpackage

/* File: pkg/irq_flag_if.sv */
`timescale 1ns/1ps
interface irq_flag_if;
  logic [7:0] set_evt;
  logic [7:0] excl_clr;
  logic rd_clr;
  logic [7:0] mask;
  logic show_masked;
  logic [7:0] status;

  modport owner (
    output set_evt,
    output excl_clr,
    output rd_clr,
    output mask,
    output show_masked,
    input status
  );

  modport flags (
    input set_evt,
    input excl_clr,
    input rd_clr,
    input mask,
    input show_masked,
    output status
  );
endinterface

/* File: hdl/irq_flag_reg.sv */
`timescale 1ns/1ps
`include "radio_irq_consts.svh"
module irq_flag_reg (
  input wire logic sys_clk,
  input wire logic nrst,
  irq_flag_if.flags bus
);
  import radio_irq_pkg::*;

  byte_t visible_set;

  // ----------------------------------------
  // Sticky flags
  // ----------------------------------------
  // A masked event is dropped here when mask mode hides it
  assign visible_set = bus.set_evt & (bus.mask | {8{bus.show_masked}});

  // Set is applied last so a fresh event survives a clearing read
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      bus.status <= `STATUS_RESET;
    else
      bus.status <= (bus.status & ~bus.excl_clr & ~{8{bus.rd_clr}}) | visible_set;
  end
endmodule

/* File: hdl/radio_baseband_irq_status.sv */
`timescale 1ns/1ps
`include "radio_irq_consts.svh"
module radio_baseband_irq_status #(
  parameter int THR_W = 11
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic reg_rd,
  input wire logic reg_wr,
  input wire logic [3:0] reg_sel,
  input wire radio_irq_pkg::byte_t reg_wdata,
  input wire logic cmd_valid,
  input wire logic cmd_high,
  input wire radio_irq_pkg::trx_cmd_e cmd_code,
  input wire logic power_up_done,
  input wire logic wake_done,
  input wire logic reset_done,
  input wire logic rx_byte,
  input wire logic gain_hold,
  input wire logic gain_release,
  input wire logic tx_frame_end,
  input wire logic ext_match,
  input wire logic addr_match,
  input wire logic rx_frame_end,
  input wire logic rx_frame_start,
  input wire logic [3:0] radio_evt,
  output radio_irq_pkg::byte_t rd_data,
  output logic irq,
  output radio_irq_pkg::trx_state_e trx_state
);
  import radio_irq_pkg::*;

  irq_flag_if ch [3] ();

  byte_t bb_mask;
  byte_t low_mask;
  byte_t high_mask;
  byte_t cfg;
  logic [THR_W-1:0] thr;
  logic [THR_W-1:0] byte_cnt;
  logic sleep_low;
  logic sleep_high;
  logic buffer_level_flag;
  logic wake_both;
  logic wake_low;
  logic trx_ready_flag;
  logic mask_visibility_mode;
  logic force_wake_mask;
  trx_state_e next_state;
  byte_t bb_set;
  byte_t low_set;
  byte_t high_set;
  byte_t next_rd_data;
  logic next_irq;

  assign mask_visibility_mode = cfg[`CFG_MASK_MODE];
  // Decoded from the next state so the bit already reads 1 in a state's first cycle
  assign force_wake_mask = (next_state == ST_POWER_ON) || (next_state == ST_SLEEP)
    || (next_state == ST_DEEP_SLEEP) || (next_state == ST_RESET);

  // ----------------------------------------
  // Register writes
  // ----------------------------------------
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      bb_mask <= `MASK_RESET;
      cfg <= `CFG_RESET;
      thr <= `THR_RESET;
    end
    else if (reg_wr)
    begin
      case (reg_sel)
        `SEL_BB_MASK: bb_mask <= reg_wdata;
        `SEL_CFG: cfg <= reg_wdata;
        `SEL_THR_LO: thr[7:0] <= reg_wdata;
        `SEL_THR_HI: thr[THR_W-1:8] <= reg_wdata[THR_W-9:0];
        default: ;
      endcase
    end
  end

  // Wake mask bit is held at 1 in low-power and reset states
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      low_mask <= `MASK_RESET;
      high_mask <= `MASK_RESET;
    end
    else
    begin
      if (reg_wr && reg_sel == `SEL_LOW_MASK)
        low_mask <= reg_wdata;
      if (reg_wr && reg_sel == `SEL_HIGH_MASK)
        high_mask <= reg_wdata;
      if (force_wake_mask)
      begin
        low_mask[`RF_WAKEUP] <= 1'b1;
        high_mask[`RF_WAKEUP] <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Transceiver state
  // ----------------------------------------
  // Deep sleep needs the sleep command on both radios
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      sleep_low <= 1'b0;
      sleep_high <= 1'b0;
    end
    else if (trx_state == ST_DEEP_SLEEP || next_state == ST_TRXOFF)
    begin
      sleep_low <= 1'b0;
      sleep_high <= 1'b0;
    end
    else if (cmd_valid && cmd_code == CMD_SLEEP)
    begin
      if (cmd_high)
        sleep_high <= 1'b1;
      else
        sleep_low <= 1'b1;
    end
  end

  always_comb
  begin
    next_state = trx_state;
    wake_both = 1'b0;
    wake_low = 1'b0;
    trx_ready_flag = 1'b0;
    case (trx_state)
      ST_POWER_ON:
        if (power_up_done)
        begin
          next_state = ST_TRXOFF;
          wake_both = 1'b1;
        end
      ST_RESET:
        if (reset_done)
        begin
          next_state = ST_TRXOFF;
          wake_both = 1'b1;
        end
      ST_SLEEP:
        if (wake_done)
        begin
          next_state = ST_TRXOFF;
          wake_low = 1'b1;
        end
      ST_DEEP_SLEEP:
        if (wake_done)
        begin
          next_state = ST_TRXOFF;
          wake_both = 1'b1;
        end
      ST_TX:
        if (tx_frame_end)
          next_state = ST_TRANSMIT_PREPARE_STATE;
      ST_RX:
        if (rx_frame_end)
          next_state = ST_TRANSMIT_PREPARE_STATE;
      default: ;
    endcase
    if (cmd_valid && !cmd_high && trx_state != ST_SLEEP && trx_state != ST_DEEP_SLEEP
      && trx_state != ST_POWER_ON)
    begin
      case (cmd_code)
        CMD_RESET: next_state = ST_RESET;
        CMD_TRXOFF: next_state = ST_TRXOFF;
        CMD_TRANSMIT_PREPARE_STATE:
          if (trx_state != ST_TRANSMIT_PREPARE_STATE)
          begin
            next_state = ST_TRANSMIT_PREPARE_STATE;
            trx_ready_flag = 1'b1;
          end
        CMD_TX: if (trx_state == ST_TRANSMIT_PREPARE_STATE) next_state = ST_TX;
        CMD_RX: if (trx_state == ST_TRANSMIT_PREPARE_STATE || trx_state == ST_TRXOFF) next_state = ST_RX;
        default: ;
      endcase
    end
    if (sleep_low && sleep_high && trx_state == ST_SLEEP)
      next_state = ST_DEEP_SLEEP;
    else if (sleep_low && trx_state != ST_SLEEP && trx_state != ST_DEEP_SLEEP)
      next_state = ST_SLEEP;
  end

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      trx_state <= ST_POWER_ON;
    else
      trx_state <= next_state;
  end

  // ----------------------------------------
  // Frame buffer level
  // ----------------------------------------
  // Count saturates so a long frame cannot wrap and flag twice
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      byte_cnt <= '0;
    else if (trx_state != ST_RX || rx_frame_start)
      byte_cnt <= '0;
    else if (rx_byte && byte_cnt != '1)
      byte_cnt <= byte_cnt + THR_W'(1);
  end

  assign buffer_level_flag = (trx_state == ST_RX) && rx_byte && (byte_cnt == thr);

  // ----------------------------------------
  // Status channels
  // ----------------------------------------
  always_comb
  begin
    bb_set = 8'h00;
    bb_set[`BB_BUFFER_LEVEL] = buffer_level_flag;
    bb_set[`BB_GAIN_RELEASE] = gain_release;
    bb_set[`BB_GAIN_HOLD] = gain_hold;
    bb_set[`BB_TX_DONE] = tx_frame_end && trx_state == ST_TX;
    bb_set[`BB_EXT_MATCH] = ext_match;
    bb_set[`BB_ADDR_MATCH] = addr_match;
    bb_set[`BB_RX_DONE] = rx_frame_end && trx_state == ST_RX;
    bb_set[`BB_RX_START] = rx_frame_start;
    low_set = {2'b00, radio_evt, trx_ready_flag, wake_both | wake_low};
    high_set = {7'h00, wake_both};
  end

  assign ch[0].set_evt = bb_set;
  assign ch[0].excl_clr = {1'b0, gain_hold, gain_release, 5'h00};
  assign ch[0].rd_clr = reg_rd && reg_sel == `SEL_BB_STATUS;
  assign ch[0].mask = bb_mask;
  assign ch[1].set_evt = low_set;
  assign ch[1].excl_clr = 8'h00;
  assign ch[1].rd_clr = reg_rd && reg_sel == `SEL_LOW_STATUS;
  assign ch[1].mask = low_mask;
  assign ch[2].set_evt = high_set;
  assign ch[2].excl_clr = 8'h00;
  assign ch[2].rd_clr = reg_rd && reg_sel == `SEL_HIGH_STATUS;
  assign ch[2].mask = high_mask;

  for (genvar g = 0; g < 3; g++)
  begin : g_chan
    assign ch[g].show_masked = mask_visibility_mode;
    irq_flag_reg u_flags (
      .sys_clk(sys_clk),
      .nrst(nrst),
      .bus(ch[g])
    );
  end

  // ----------------------------------------
  // Read data and interrupt pin
  // ----------------------------------------
  always_comb
  begin
    case (reg_sel)
      `SEL_BB_STATUS: next_rd_data = ch[0].status;
      `SEL_LOW_STATUS: next_rd_data = ch[1].status;
      `SEL_HIGH_STATUS: next_rd_data = ch[2].status;
      `SEL_BB_MASK: next_rd_data = bb_mask;
      `SEL_LOW_MASK: next_rd_data = low_mask;
      `SEL_HIGH_MASK: next_rd_data = high_mask;
      `SEL_CFG: next_rd_data = cfg;
      `SEL_THR_LO: next_rd_data = thr[7:0];
      `SEL_THR_HI: next_rd_data = {{(16-THR_W){1'b0}}, thr[THR_W-1:8]};
      default: next_rd_data = 8'h00;
    endcase
  end

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      rd_data <= 8'h00;
    else if (reg_rd)
      rd_data <= next_rd_data;
  end

  // Pin lags the status by one cycle; kept for a glitch-free registered output
  assign next_irq = |(ch[0].status & bb_mask) || |(ch[1].status & low_mask)
    || |(ch[2].status & high_mask);

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      irq <= 1'b0;
    else
      irq <= next_irq;
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_read_clears;
    @(posedge sys_clk) disable iff (!nrst)
    (ch[0].rd_clr && bb_set == 8'h00) |=> (ch[0].status == 8'h00);
  endproperty
  a_read_clears: assert property (p_read_clears) else $error("status not cleared by read");

  property p_set_wins;
    @(posedge sys_clk) disable iff (!nrst)
    (ch[0].rd_clr && mask_visibility_mode && bb_set != 8'h00)
      |=> ((ch[0].status & $past(bb_set)) == $past(bb_set));
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("event lost on clearing read");

  property p_gain_excl;
    @(posedge sys_clk) disable iff (!nrst)
    (gain_hold && !gain_release && mask_visibility_mode)
      |=> (ch[0].status[`BB_GAIN_HOLD] && !ch[0].status[`BB_GAIN_RELEASE]);
  endproperty
  a_gain_excl: assert property (p_gain_excl) else $error("gain flags not exclusive");

  property p_tx_end;
    @(posedge sys_clk) disable iff (!nrst)
    (trx_state == ST_TX && tx_frame_end && !cmd_valid && !sleep_low && mask_visibility_mode)
      |=> (trx_state == ST_TRANSMIT_PREPARE_STATE && ch[0].status[`BB_TX_DONE]
        && !$rose(ch[1].status[`RF_TRX_READY]));
  endproperty
  a_tx_end: assert property (p_tx_end) else $error("tx end handling wrong");

  property p_rx_end;
    @(posedge sys_clk) disable iff (!nrst)
    (trx_state == ST_RX && rx_frame_end && !cmd_valid && !sleep_low && mask_visibility_mode)
      |=> (trx_state == ST_TRANSMIT_PREPARE_STATE && ch[0].status[`BB_RX_DONE]
        && !$rose(ch[1].status[`RF_TRX_READY]));
  endproperty
  a_rx_end: assert property (p_rx_end) else $error("rx end handling wrong");

  property p_wake;
    @(posedge sys_clk) disable iff (!nrst)
    (trx_state == ST_POWER_ON && power_up_done)
      |=> (ch[1].status[`RF_WAKEUP] && ch[2].status[`RF_WAKEUP]);
  endproperty
  a_wake: assert property (p_wake) else $error("wake flag missing");

  property p_irq_pin;
    @(posedge sys_clk) disable iff (!nrst)
    ##1 (irq == $past(next_irq));
  endproperty
  a_irq_pin: assert property (p_irq_pin) else $error("irq pin mismatch");

  property p_mask_force;
    @(posedge sys_clk) disable iff (!nrst)
    (trx_state == ST_SLEEP) |-> (low_mask[`RF_WAKEUP] && high_mask[`RF_WAKEUP]);
  endproperty
  a_mask_force: assert property (p_mask_force) else $error("wake mask not forced");

  property p_hidden;
    @(posedge sys_clk) disable iff (!nrst)
    (!mask_visibility_mode && !bb_mask[`BB_EXT_MATCH] && !ch[0].status[`BB_EXT_MATCH])
      |=> !ch[0].status[`BB_EXT_MATCH];
  endproperty
  a_hidden: assert property (p_hidden) else $error("masked event shown");

  property p_level;
    @(posedge sys_clk) disable iff (!nrst)
    (buffer_level_flag && mask_visibility_mode) |=> ch[0].status[`BB_BUFFER_LEVEL];
  endproperty
  a_level: assert property (p_level) else $error("buffer level flag missing");
endmodule

/* File: verif/host_model.sv */
`timescale 1ns/1ps
`include "radio_irq_consts.svh"
module host_model (
  input wire logic sys_clk,
  output logic reg_rd,
  output logic reg_wr,
  output logic [3:0] reg_sel,
  output radio_irq_pkg::byte_t reg_wdata,
  output logic cmd_valid,
  output logic cmd_high,
  output radio_irq_pkg::trx_cmd_e cmd_code,
  input wire radio_irq_pkg::byte_t rd_data
);
  import radio_irq_pkg::*;
  localparam int DLY = 2;
  realtime t_end = -1.0;
  // ------------------------------------------
  // Idle bus
  // ------------------------------------------
  // Idle select is unmapped, so a stray strobe reads 00 and writes no register
  initial
  begin
    reg_rd = 1'b0;
    reg_wr = 1'b0;
    reg_sel = 4'hf;
    reg_wdata = 8'h00;
    cmd_valid = 1'b0;
    cmd_high = 1'b0;
    cmd_code = CMD_NOP;
  end
  // ------------------------------------------
  // Requests
  // ------------------------------------------
  // Back-to-back requests let one edge pass so no line is driven twice in a time step
  task automatic gap;
    if ($realtime == t_end)
    begin
      @(posedge sys_clk);
      #DLY;
    end
  endtask
  // Each request is held over one sampling edge, then dropped just after it
  task automatic rd(input logic [3:0] sel, output byte_t data);
    gap();
    reg_rd = 1'b1;
    reg_sel = sel;
    @(posedge sys_clk);
    #DLY;
    data = rd_data;
    reg_rd = 1'b0;
    reg_sel = 4'hf;
    t_end = $realtime;
  endtask
  // Released data lines show the inverse so stale values are never trusted
  task automatic wr(input logic [3:0] sel, input byte_t data);
    gap();
    reg_wr = 1'b1;
    reg_sel = sel;
    reg_wdata = data;
    @(posedge sys_clk);
    #DLY;
    reg_wr = 1'b0;
    reg_sel = 4'hf;
    reg_wdata = ~data;
    t_end = $realtime;
  endtask
  task automatic cmd(input logic high, input trx_cmd_e code);
    gap();
    cmd_valid = 1'b1;
    cmd_high = high;
    cmd_code = code;
    @(posedge sys_clk);
    #DLY;
    cmd_valid = 1'b0;
    cmd_code = CMD_NOP;
    t_end = $realtime;
  endtask
  // A wake-up from power-on, reset or deep sleep flags both radio registers, so both are read to clear it
  task automatic clear_wake(output byte_t lo, output byte_t hi);
    rd(`SEL_LOW_STATUS, lo);
    rd(`SEL_HIGH_STATUS, hi);
  endtask
endmodule

/* File: verif/tb_top.sv */
`timescale 1ns/1ps
`include "radio_irq_consts.svh"
module tb_top;
  import radio_irq_pkg::*;
  localparam int DLY = 2;
  logic sys_clk, nrst, reg_rd, reg_wr, cmd_valid, cmd_high, irq;
  logic power_up_done, wake_done, reset_done, rx_byte, gain_hold, gain_release;
  logic tx_frame_end, ext_match, addr_match, rx_frame_end, rx_frame_start;
  logic [3:0] reg_sel, radio_evt;
  byte_t reg_wdata, rd_data;
  trx_cmd_e cmd_code;
  trx_state_e trx_state;
  int err_total = 0;
  int n_tests = 0;
  // ------------------------------------------
  // Instances
  // ------------------------------------------
  radio_baseband_irq_status i_dut (.sys_clk(sys_clk), .nrst(nrst), .reg_rd(reg_rd),
    .reg_wr(reg_wr), .reg_sel(reg_sel), .reg_wdata(reg_wdata), .cmd_valid(cmd_valid),
    .cmd_high(cmd_high), .cmd_code(cmd_code), .power_up_done(power_up_done),
    .wake_done(wake_done), .reset_done(reset_done), .rx_byte(rx_byte),
    .gain_hold(gain_hold), .gain_release(gain_release), .tx_frame_end(tx_frame_end),
    .ext_match(ext_match), .addr_match(addr_match), .rx_frame_end(rx_frame_end),
    .rx_frame_start(rx_frame_start), .radio_evt(radio_evt), .rd_data(rd_data),
    .irq(irq), .trx_state(trx_state));
  host_model i_host (.sys_clk(sys_clk), .reg_rd(reg_rd), .reg_wr(reg_wr),
    .reg_sel(reg_sel), .reg_wdata(reg_wdata), .cmd_valid(cmd_valid),
    .cmd_high(cmd_high), .cmd_code(cmd_code), .rd_data(rd_data));
  initial
  begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  // ------------------------------------------
  // Helpers
  // ------------------------------------------
  task automatic print_verdict;
    if (err_total == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #DLY;
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    cyc(1);
    s = 1'b0;
  endtask
  task automatic chk(input byte_t got, input byte_t exp);
    n_tests++;
    if (got !== exp)
    begin
      err_total++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rchk(input logic [3:0] sel, input byte_t exp);
    byte_t d;
    i_host.rd(sel, d);
    chk(d, exp);
  endtask
  task automatic ichk(input logic exp);
    chk({7'h00, irq}, {7'h00, exp});
  endtask
  // Bounded wait; a stuck state machine ends the run at once
  task automatic wait_state(input trx_state_e s);
    for (int k = 0; k < 16 && trx_state !== s; k++)
      cyc(1);
    n_tests++;
    if (trx_state !== s)
    begin
      err_total++;
      $display("BAD %0t state wait timed out", $time);
      print_verdict();
    end
  endtask
  // ------------------------------------------
  // Scenarios
  // ------------------------------------------
  task automatic t_power_up;
    byte_t lo, hi;
    rchk(`SEL_CFG, `CFG_RESET);
    rchk(`SEL_BB_MASK, `MASK_RESET);
    rchk(`SEL_LOW_MASK, 8'h01);
    pulse(power_up_done);
    wait_state(ST_TRXOFF);
    radio_evt = 4'h5;
    cyc(1);
    radio_evt = 4'h0;
    cyc(1);
    ichk(1'b1);
    i_host.clear_wake(lo, hi);
    chk(lo, 8'h15);
    chk(hi, 8'h01);
    cyc(2);
    ichk(1'b0);
    i_host.wr(`SEL_BB_STATUS, 8'hff);
    rchk(`SEL_BB_STATUS, 8'h00);
    rchk(4'h9, 8'h00);
  endtask
  task automatic t_mask;
    pulse(ext_match);
    pulse(addr_match);
    pulse(rx_frame_start);
    cyc(1);
    ichk(1'b0);
    rchk(`SEL_BB_STATUS, 8'h0d);
    rchk(`SEL_BB_STATUS, 8'h00);
    i_host.wr(`SEL_CFG, 8'h00);
    pulse(ext_match);
    rchk(`SEL_BB_STATUS, 8'h00);
    i_host.wr(`SEL_BB_MASK, 8'h08);
    pulse(ext_match);
    cyc(1);
    ichk(1'b1);
    cyc(3);
    ichk(1'b1);
    rchk(`SEL_BB_STATUS, 8'h08);
    cyc(1);
    ichk(1'b0);
    i_host.wr(`SEL_CFG, `CFG_RESET);
    i_host.wr(`SEL_BB_MASK, 8'h00);
  endtask
  task automatic t_gain_and_collide;
    byte_t d;
    pulse(gain_release);
    pulse(gain_hold);
    rchk(`SEL_BB_STATUS, 8'h20);
    pulse(gain_hold);
    pulse(gain_release);
    rchk(`SEL_BB_STATUS, 8'h40);
    pulse(ext_match);
    addr_match = 1'b1;
    i_host.rd(`SEL_BB_STATUS, d);
    addr_match = 1'b0;
    chk(d, 8'h08);
    rchk(`SEL_BB_STATUS, 8'h04);
  endtask
  task automatic t_frames;
    i_host.cmd(1'b0, CMD_TRANSMIT_PREPARE_STATE);
    wait_state(ST_TRANSMIT_PREPARE_STATE);
    cyc(1);
    rchk(`SEL_LOW_STATUS, 8'h02);
    i_host.cmd(1'b0, CMD_TX);
    wait_state(ST_TX);
    pulse(tx_frame_end);
    chk({5'h00, trx_state}, {5'h00, ST_TRANSMIT_PREPARE_STATE});
    rchk(`SEL_BB_STATUS, 8'h10);
    rchk(`SEL_LOW_STATUS, 8'h00);
    i_host.wr(`SEL_THR_LO, 8'h02);
    i_host.wr(`SEL_THR_HI, 8'h00);
    i_host.cmd(1'b0, CMD_RX);
    wait_state(ST_RX);
    pulse(rx_frame_start);
    pulse(rx_byte);
    pulse(rx_byte);
    rchk(`SEL_BB_STATUS, 8'h01);
    pulse(rx_byte);
    rchk(`SEL_BB_STATUS, 8'h80);
    pulse(rx_frame_end);
    chk({5'h00, trx_state}, {5'h00, ST_TRANSMIT_PREPARE_STATE});
    rchk(`SEL_BB_STATUS, 8'h02);
    rchk(`SEL_LOW_STATUS, 8'h00);
    pulse(rx_frame_end);
    rchk(`SEL_BB_STATUS, 8'h00);
  endtask
  task automatic t_sleep;
    i_host.wr(`SEL_LOW_MASK, 8'h00);
    rchk(`SEL_LOW_MASK, 8'h00);
    i_host.cmd(1'b0, CMD_SLEEP);
    wait_state(ST_SLEEP);
    rchk(`SEL_LOW_MASK, 8'h01);
    i_host.cmd(1'b1, CMD_SLEEP);
    wait_state(ST_DEEP_SLEEP);
    pulse(wake_done);
    cyc(1);
    ichk(1'b1);
    rchk(`SEL_LOW_STATUS, 8'h01);
    cyc(1);
    ichk(1'b1);
    rchk(`SEL_HIGH_STATUS, 8'h01);
    cyc(1);
    ichk(1'b0);
    i_host.cmd(1'b0, CMD_RESET);
    wait_state(ST_RESET);
    pulse(reset_done);
    wait_state(ST_TRXOFF);
    rchk(`SEL_LOW_STATUS, 8'h01);
    rchk(`SEL_HIGH_STATUS, 8'h01);
  endtask
  // ------------------------------------------
  // Main sequence
  // ------------------------------------------
  initial
  begin
    {nrst, power_up_done, wake_done, reset_done, rx_byte, gain_hold} = 6'h00;
    {gain_release, tx_frame_end, ext_match, addr_match} = 4'h0;
    {rx_frame_end, rx_frame_start} = 2'h0;
    radio_evt = 4'h0;
    cyc(3);
    nrst = 1'b1;
    t_power_up;
    t_mask;
    t_gain_and_collide;
    t_frames;
    t_sleep;
    print_verdict;
  end
endmodule
